// ==== verilog/smp_pkg.sv ====
package smp_pkg;
  // ==========================================================
  // timing
  localparam int CLK_NS = 10;
  localparam int OSC_HALF_NS = 250;
  localparam int OSC_HALF_CYC = OSC_HALF_NS / CLK_NS;
  localparam int TICK_NS = 250;
  localparam int TICK_CYC = TICK_NS / CLK_NS;
  // ==========================================================
  // register byte offsets
  localparam logic [5:0] OFF_CMD = 6'h00;
  localparam logic [5:0] OFF_TARGET = 6'h04;
  localparam logic [5:0] OFF_ACC = 6'h08;
  localparam logic [5:0] OFF_DEC = 6'h0c;
  localparam logic [5:0] OFF_MAX = 6'h10;
  localparam logic [5:0] OFF_MIN = 6'h14;
  localparam logic [5:0] OFF_FS = 6'h18;
  localparam logic [5:0] OFF_MODE = 6'h1c;
  localparam logic [5:0] OFF_POS = 6'h20;
  localparam logic [5:0] OFF_SPEED = 6'h24;
  localparam logic [5:0] OFF_STATUS = 6'h28;
  localparam logic [5:0] OFF_MARK = 6'h2c;
  // ==========================================================
  // fields
  localparam int CMD_DIR_BIT = 4;
  localparam int CMD_MARK_BIT = 5;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_UNDERVOLTAGE_STATUS_BIT_BIT = 1;
  localparam int ST_BRIDGE_BIT = 2;
  localparam int ST_DIR_BIT = 3;
  localparam int ST_FS_BIT = 4;
  localparam int ST_STATE_LSB = 5;
  localparam logic [2:0] SEL_MAX = 3'h4;
  // ==========================================================
  // reset values
  localparam logic [11:0] ACC_RST = 12'h08a;
  localparam logic [11:0] DEC_RST = 12'h08a;
  localparam logic [9:0] MAX_RST = 10'h041;
  localparam logic [11:0] MIN_RST = 12'h000;
  localparam logic [9:0] FS_RST = 10'h027;
  localparam logic [2:0] SEL_RST = 3'h4;
  // ==========================================================
  // commands and states
  typedef enum logic [3:0] {
    CMD_RUN = 4'h0,
    CMD_UNTIL = 4'h1,
    CMD_RELEASE = 4'h2,
    CMD_TO_POSITION_CMD = 4'h3,
    CMD_DIRECTED_POSITION_CMD = 4'h4,
    CMD_HOME = 4'h5,
    CMD_MARK = 4'h6,
    CMD_MOVE = 4'h7,
    CMD_SSTOP = 4'h8,
    CMD_HSTOP = 4'h9,
    CMD_SREL = 4'ha,
    CMD_HREL = 4'hb
  } smp_cmd_e;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_MOVE = 2'b01,
    ST_STOP = 2'b11
  } smp_state_e;
endpackage : smp_pkg

// ==== verilog/smp_core.sv ====
// Added by the designer: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ns
// Overview of operation
// - reset gives defaults and 2 MHz clock out
// - after reset bridges off, undervoltage_status_bit low, alarm low
// - held in reset, outputs idle, bridges off
// - every motion command, CMD_SSTOP and CMD_HSTOP enable bridges
// - step select up to sixteen microsteps
// - step mode change zeroes electrical position
// - auto full step above threshold speed
// - signed 22-bit absolute position
// - position counts in selected step units
// - speed units independent of step mode
// - acc and dec from 1 to 4094
// - min speed 0 to 4095
// - max speed 1 to 1023
// - profile stays inside programmed limits
// - run starts at min speed, ramps, holds
// - new run accepted any time
// - to_position_cmd shortest path unless directed
// - move exact microsteps in given direction
// - short moves brake before max speed
// - four command classes accepted
// - alarm and busy are open drain low
// - standby input low resets logic
// - busy low while command executes
module smp_core
  import smp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic standby_reset_n,
  input wire logic supply_ok,
  input wire logic switch_in,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic step_pulse,
  output logic step_dir,
  output logic [5:0] elec_pos,
  output logic bridge_en,
  output logic full_step_mode,
  output logic oscillator_output_pin,
  output logic alarm_o,
  output logic alarm_oe_n,
  output logic busy_o,
  output logic busy_oe_n
);
  // ==========================================================
  // helpers
  function automatic logic [11:0] sat12(input logic [11:0] v);
    sat12 = (v == 12'h000) ? 12'h001 : (v == 12'hfff) ? 12'hffe : v;
  endfunction : sat12
  function automatic logic [31:0] clamp(input logic [31:0] v,
                                        input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : (v > hi) ? hi : v;
  endfunction : clamp

  // ==========================================================
  // logic reset
  logic hold_reg;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) hold_reg <= 1'b1;
    else hold_reg <= ~standby_reset_n;
  end
  wire lrst = rst | hold_reg;

  // ==========================================================
  // registers
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [11:0] acc_reg;
  logic [11:0] dec_reg;
  logic [9:0] max_reg;
  logic [11:0] min_reg;
  logic [9:0] fs_reg;
  logic [2:0] sel_reg;

  // ==========================================================
  // motion state registers
  logic [21:0] target_reg;
  logic [21:0] pos_reg;
  logic [21:0] mark_reg;
  logic [21:0] rem_reg;
  logic [31:0] speed_reg;
  logic [31:0] tgt_reg;
  logic [39:0] step_acc_reg;
  logic [5:0] elec_reg;
  smp_state_e state_reg;
  logic dir_reg;
  logic bounded_reg;
  logic [1:0] sw_mode_reg;
  logic sw_mark_reg;
  logic hiz_after_reg;
  logic bridge_reg;
  logic fs_flag_reg;

  // ==========================================================
  // pin and timing registers
  logic undervoltage_status_bit_reg;
  logic sw_prev_reg;
  logic step_reg;
  logic [4:0] tick_cnt_reg;
  logic [4:0] osc_cnt_reg;
  logic osc_reg;

  // ==========================================================
  // bus decode
  wire bus_req = avs_read | avs_write;
  wire wr_go = avs_write & ack_reg;
  wire rd_go = avs_read & ack_reg;
  wire wr_cmd = wr_go & (avs_address == OFF_CMD) & supply_ok;
  wire wr_pos = wr_go & (avs_address == OFF_POS);
  wire wr_mode = wr_go & (avs_address == OFF_MODE);
  wire rd_status = rd_go & (avs_address == OFF_STATUS);
  wire [3:0] op = avs_writedata[3:0];
  wire cmd_dir = avs_writedata[CMD_DIR_BIT];

  // ==========================================================
  // status word and read select
  wire [31:0] status_w = {25'h0, state_reg, fs_flag_reg, dir_reg,
                          bridge_reg, undervoltage_status_bit_reg, state_reg != ST_IDLE};
  wire [31:0] rd_mux =
    (avs_address == OFF_TARGET) ? {10'h0, target_reg} :
    (avs_address == OFF_ACC) ? {20'h0, acc_reg} :
    (avs_address == OFF_DEC) ? {20'h0, dec_reg} :
    (avs_address == OFF_MAX) ? {22'h0, max_reg} :
    (avs_address == OFF_MIN) ? {20'h0, min_reg} :
    (avs_address == OFF_FS) ? {22'h0, fs_reg} :
    (avs_address == OFF_MODE) ? {29'h0, sel_reg} :
    (avs_address == OFF_POS) ? {{10{pos_reg[21]}}, pos_reg} :
    (avs_address == OFF_SPEED) ? speed_reg :
    (avs_address == OFF_STATUS) ? status_w :
    (avs_address == OFF_MARK) ? {{10{mark_reg[21]}}, mark_reg} :
    32'h0;

  // ==========================================================
  // bus answer, one wait state
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign avs_readdata = rdata_reg;

  always_ff @(posedge core_clk or posedge lrst) begin
    if (lrst) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
      if (avs_read & ~ack_reg) rdata_reg <= rd_mux;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge core_clk or posedge lrst) begin
    if (lrst) begin
      acc_reg <= ACC_RST;
      dec_reg <= DEC_RST;
      max_reg <= MAX_RST;
      min_reg <= MIN_RST;
      fs_reg <= FS_RST;
      sel_reg <= SEL_RST;
      target_reg <= 22'h0;
    end else if (wr_go) begin
      case (avs_address)
        OFF_TARGET: target_reg <= avs_writedata[21:0];
        OFF_ACC: acc_reg <= sat12(avs_writedata[11:0]);
        OFF_DEC: dec_reg <= sat12(avs_writedata[11:0]);
        OFF_MAX: max_reg <= (avs_writedata[9:0] == 10'h0) ? 10'h001 :
                            avs_writedata[9:0];
        OFF_MIN: min_reg <= avs_writedata[11:0];
        OFF_FS: fs_reg <= avs_writedata[9:0];
        OFF_MODE: sel_reg <= (avs_writedata[2:0] > SEL_MAX) ? SEL_MAX :
                             avs_writedata[2:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // speed profile arithmetic, units of 2^-40 step per tick
  wire [31:0] vmin = {4'h0, min_reg, 16'h0};
  wire [31:0] vmax = {max_reg, 22'h0};
  wire [31:0] vfs = {fs_reg, 22'h0};
  wire [31:0] acc_w = {20'h0, acc_reg};
  wire [31:0] dec_w = {20'h0, dec_reg};

  // ==========================================================
  // target speed and braking distance
  wire [31:0] run_tgt = clamp({target_reg[9:0], 22'h0}, vmin, vmax);
  wire [31:0] ceil_v = bounded_reg ? vmax : tgt_reg;
  wire [63:0] vsq = 64'(speed_reg) * 64'(speed_reg);
  wire [67:0] lhs = 68'(vsq) << sel_reg;
  wire [33:0] rhs = 34'(dec_reg) * 34'(rem_reg);
  wire brake = bounded_reg & ({8'h0, lhs} >= {1'b0, rhs, 41'h0});

  // ==========================================================
  // next speed
  wire stopping = state_reg == ST_STOP;
  wire decel = stopping | brake | (speed_reg > ceil_v);
  wire [31:0] floor_v = (stopping | brake) ? vmin : ceil_v;
  wire [32:0] up_sum = 33'(speed_reg) + 33'(acc_w);
  wire [32:0] dn_lim = 33'(floor_v) + 33'(dec_w);
  wire [31:0] v_dn = (33'(speed_reg) >= dn_lim) ? speed_reg - dec_w : floor_v;
  wire [31:0] v_up = (up_sum <= 33'(ceil_v)) ? up_sum[31:0] : ceil_v;
  wire [31:0] v_next = decel ? v_dn : v_up;
  wire stop_done = stopping & (speed_reg <= vmin);

  // ==========================================================
  // step generation
  wire tick = tick_cnt_reg == 5'(TICK_CYC - 1);
  wire [40:0] acc_sum = {1'b0, step_acc_reg} + (41'(speed_reg) << sel_reg);
  wire step_now = acc_sum[40];
  wire [5:0] elec_inc = 6'h10 >> sel_reg;

  // ==========================================================
  // position and electrical steps
  wire [21:0] pos_step = dir_reg ? pos_reg + 22'h1 : pos_reg - 22'h1;
  wire [5:0] elec_step = dir_reg ? elec_reg + elec_inc : elec_reg - elec_inc;

  // ==========================================================
  // command decode
  wire [21:0] goal = (op == CMD_HOME) ? 22'h0 :
                     (op == CMD_MARK) ? mark_reg : target_reg;
  wire [21:0] diff = goal - pos_reg;
  wire [21:0] short_dist = diff[21] ? 22'h0 - diff : diff;
  wire [21:0] dir_dist = cmd_dir ? diff : 22'h0 - diff;

  // ==========================================================
  // command classes
  wire is_run = (op == CMD_RUN) | (op == CMD_UNTIL) | (op == CMD_RELEASE);
  wire is_to_position_cmd = (op == CMD_TO_POSITION_CMD) | (op == CMD_HOME) | (op == CMD_MARK);
  wire is_bnd = is_to_position_cmd | (op == CMD_DIRECTED_POSITION_CMD) | (op == CMD_MOVE);
  wire [21:0] new_dist = is_to_position_cmd ? short_dist :
                         (op == CMD_DIRECTED_POSITION_CMD) ? dir_dist : target_reg;
  wire new_dir = is_to_position_cmd ? ~diff[21] : cmd_dir;

  // ==========================================================
  // switch edges
  wire sw_fall = sw_prev_reg & ~switch_in;
  wire sw_rise = ~sw_prev_reg & switch_in;
  wire sw_hit = (state_reg == ST_MOVE) &
                (((sw_mode_reg == 2'd1) & sw_fall) | ((sw_mode_reg == 2'd2) & sw_rise));
  wire start_v = state_reg == ST_IDLE;

  // ==========================================================
  // motion control
  always_ff @(posedge core_clk or posedge lrst) begin
    if (lrst) begin
      state_reg <= ST_IDLE;
      speed_reg <= 32'h0;
      tgt_reg <= 32'h0;
      step_acc_reg <= 40'h0;
      rem_reg <= 22'h0;
      pos_reg <= 22'h0;
      mark_reg <= 22'h0;
      elec_reg <= 6'h0;
      dir_reg <= 1'b1;
      bounded_reg <= 1'b0;
      sw_mode_reg <= 2'd0;
      sw_mark_reg <= 1'b0;
      hiz_after_reg <= 1'b0;
      bridge_reg <= 1'b0;
      step_reg <= 1'b0;
    end else begin
      step_reg <= 1'b0;
      if (wr_mode) elec_reg <= 6'h0;
      if (wr_pos) pos_reg <= avs_writedata[21:0];
      if (wr_cmd) begin
        if (op <= CMD_SSTOP || op == CMD_HSTOP) bridge_reg <= 1'b1;
        if (is_run) begin
          state_reg <= ST_MOVE;
          bounded_reg <= 1'b0;
          dir_reg <= cmd_dir;
          tgt_reg <= (op == CMD_RELEASE) ? vmin : run_tgt;
          sw_mode_reg <= (op == CMD_UNTIL) ? 2'd1 : (op == CMD_RELEASE) ? 2'd2 : 2'd0;
          sw_mark_reg <= avs_writedata[CMD_MARK_BIT];
          if (start_v) speed_reg <= vmin;
        end else if (is_bnd) begin
          state_reg <= (new_dist == 22'h0) ? ST_IDLE : ST_MOVE;
          bounded_reg <= 1'b1;
          sw_mode_reg <= 2'd0;
          rem_reg <= new_dist;
          dir_reg <= new_dir;
          if (start_v) speed_reg <= vmin;
        end else if (op == CMD_SSTOP || op == CMD_SREL) begin
          hiz_after_reg <= op == CMD_SREL;
          if (!start_v) state_reg <= ST_STOP;
          else if (op == CMD_SREL) bridge_reg <= 1'b0;
        end else if (op == CMD_HSTOP || op == CMD_HREL) begin
          state_reg <= ST_IDLE;
          speed_reg <= 32'h0;
          if (op == CMD_HREL) bridge_reg <= 1'b0;
        end
      end else if (sw_hit) begin
        if (sw_mark_reg) mark_reg <= pos_reg;
        else pos_reg <= 22'h0;
        sw_mode_reg <= 2'd0;
        hiz_after_reg <= 1'b0;
        if (sw_mode_reg == 2'd1) state_reg <= ST_STOP;
        else begin
          state_reg <= ST_IDLE;
          speed_reg <= 32'h0;
        end
      end else if (tick && state_reg != ST_IDLE) begin
        if (stop_done) begin
          state_reg <= ST_IDLE;
          speed_reg <= 32'h0;
          if (hiz_after_reg) bridge_reg <= 1'b0;
        end else begin
          speed_reg <= v_next;
          step_acc_reg <= acc_sum[39:0];
          if (step_now) begin
            step_reg <= 1'b1;
            pos_reg <= pos_step;
            if (!wr_mode) elec_reg <= elec_step;
            if (bounded_reg) begin
              rem_reg <= rem_reg - 22'h1;
              if (rem_reg == 22'h1) begin
                state_reg <= ST_IDLE;
                speed_reg <= 32'h0;
              end
            end
          end
        end
      end
    end
  end

  // ==========================================================
  // tick, oscillator out, status
  always_ff @(posedge core_clk or posedge lrst) begin
    if (lrst) begin
      tick_cnt_reg <= 5'h0;
      osc_cnt_reg <= 5'h0;
      osc_reg <= 1'b0;
      fs_flag_reg <= 1'b0;
      undervoltage_status_bit_reg <= 1'b0;
      sw_prev_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick ? 5'h0 : tick_cnt_reg + 5'h1;
      if (osc_cnt_reg == 5'(OSC_HALF_CYC - 1)) begin
        osc_cnt_reg <= 5'h0;
        osc_reg <= ~osc_reg;
      end else begin
        osc_cnt_reg <= osc_cnt_reg + 5'h1;
      end
      fs_flag_reg <= speed_reg > vfs;
      if (!supply_ok) undervoltage_status_bit_reg <= 1'b0;
      else if (rd_status) undervoltage_status_bit_reg <= 1'b1;
      sw_prev_reg <= switch_in;
    end
  end

  // ==========================================================
  // outputs
  assign step_pulse = step_reg;
  assign step_dir = dir_reg;
  assign elec_pos = elec_reg;
  assign bridge_en = bridge_reg;
  assign full_step_mode = fs_flag_reg;
  assign oscillator_output_pin = osc_reg;

  // ==========================================================
  // open drain pins
  assign alarm_o = 1'b0;
  assign alarm_oe_n = undervoltage_status_bit_reg;
  assign busy_o = 1'b0;
  assign busy_oe_n = state_reg == ST_IDLE;
endmodule : smp_core

// ==== verification/smp_core_properties.sv ====
`timescale 1ns/1ns
module smp_core_properties
  import smp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic standby_reset_n,
  input wire logic supply_ok,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic step_pulse,
  input wire logic bridge_en,
  input wire logic full_step_mode,
  input wire logic oscillator_output_pin,
  input wire logic alarm_oe_n,
  input wire logic busy_oe_n
);
  // ==========
  // helpers
  logic [7:0] gap_reg;
  logic cmd_ok;
  assign cmd_ok = avs_write && !avs_waitrequest && avs_address == OFF_CMD
    && supply_ok && standby_reset_n && avs_writedata[3:0] < 4'ha;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      gap_reg <= 8'hff;
    end else if (step_pulse) begin
      gap_reg <= 8'h00;
    end else if (gap_reg != 8'hff) begin
      gap_reg <= gap_reg + 8'h01;
    end
  end
  default clocking dflt @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========
  // properties
  a_osc_half:
    assert property (disable iff (rst || !standby_reset_n) $changed(oscillator_output_pin)
      |-> ##25 $changed(oscillator_output_pin)) else $error("osc half period wrong");
  a_reset_idle:
    assert property (disable iff (1'b0) rst |-> !bridge_en && !alarm_oe_n && busy_oe_n
      && !step_pulse && !full_step_mode) else $error("outputs active in reset");
  a_cmd_bridge:
    assert property (cmd_ok |=> bridge_en) else $error("command left bridges off");
  a_run_busy:
    assert property (cmd_ok && avs_writedata[3:0] == 4'h0 |=> !busy_oe_n)
      else $error("busy not pulled on run");
  a_step_gap:
    assert property (step_pulse |-> gap_reg >= 8'd24) else $error("steps too close");
  a_undervoltage_status_bit_alarm:
    assert property (!supply_ok [*3] |-> !alarm_oe_n) else $error("alarm not pulled");
  a_standby_reset:
    assert property (!standby_reset_n [*2] |-> !bridge_en && busy_oe_n && !alarm_oe_n)
      else $error("standby did not reset");
  a_wait_one:
    assert property ($rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("bus answer timing wrong");
  c_step: cover property (step_pulse);
  c_full: cover property ($rose(full_step_mode));
  c_refused: cover property (avs_write && !avs_waitrequest && !supply_ok);
endmodule : smp_core_properties

// ==== verification/smp_bridge_model.sv ====
`timescale 1ns/1ns
module smp_bridge_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic step_pulse,
  input wire logic step_dir,
  input wire logic bridge_en,
  output logic signed [21:0] mot_pos
);
  // ==========
  // rotor position, moves only while driven
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      mot_pos <= 22'sd0;
    end else if (step_pulse && bridge_en) begin
      mot_pos <= step_dir ? mot_pos + 22'sd1 : mot_pos - 22'sd1;
    end
  end
endmodule : smp_bridge_model

// ==== verification/tb_stepper_motion_profile_core.sv ====
`timescale 1ns/1ns
module tb_stepper_motion_profile_core
  import smp_pkg::*;
;
  // ==========
  // signals
  logic core_clk = 1'b0;
  logic rst = 1'b0;
  logic standby_reset_n = 1'b1;
  logic supply_ok = 1'b0;
  logic switch_in = 1'b1;
  logic [5:0] avs_address = 6'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic [5:0] elec_pos;
  logic avs_waitrequest, step_pulse, step_dir, bridge_en, full_step_mode;
  logic oscillator_output_pin, alarm_o, alarm_oe_n, busy_o, busy_oe_n;
  logic signed [21:0] mot_pos;
  logic signed [21:0] p0;
  logic [31:0] v;
  int n_mismatch = 0;
  int num_checks = 0;
  int seed = 26;
  typedef struct {logic [31:0] e; logic [31:0] m;} smp_exp_s;
  smp_exp_s exp_q[$];
  logic [5:0] ra[5] = '{OFF_ACC, OFF_ACC, OFF_DEC, OFF_MAX, OFF_MIN};
  logic [31:0] wv[5] = '{32'h0, 32'hfff, 32'hfff, 32'h0, 32'hfff};
  logic [31:0] ev[5] = '{32'h1, 32'hffe, 32'hffe, 32'h1, 32'hfff};
  always #(CLK_NS / 2) core_clk = ~core_clk;
  smp_core i_dut (.core_clk(core_clk), .rst(rst), .standby_reset_n(standby_reset_n),
    .supply_ok(supply_ok), .switch_in(switch_in), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .step_pulse(step_pulse), .step_dir(step_dir), .elec_pos(elec_pos),
    .bridge_en(bridge_en), .full_step_mode(full_step_mode),
    .oscillator_output_pin(oscillator_output_pin), .alarm_o(alarm_o),
    .alarm_oe_n(alarm_oe_n), .busy_o(busy_o), .busy_oe_n(busy_oe_n));
  smp_bridge_model i_motor (.core_clk(core_clk), .rst(rst), .step_pulse(step_pulse),
    .step_dir(step_dir), .bridge_en(bridge_en), .mot_pos(mot_pos));
  // ==========
  // tasks
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_read <= !w;
    avs_write <= w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) begin
      n++;
      if (n > 20) begin
        n_mismatch++;
        give_verdict();
      end
      @(posedge core_clk);
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge core_clk);
  endtask : bus
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back('{e, m});
    bus(1'b0, a, 32'h0);
  endtask : rd
  task automatic cmd(input logic [3:0] op, input logic d, input logic [31:0] t);
    wr(OFF_TARGET, t);
    wr(OFF_CMD, {27'h0, d, op});
  endtask : cmd
  task automatic wait_idle(input int lim);
    int n;
    n = 0;
    while (busy_oe_n !== 1'b1) begin
      n++;
      if (n > lim) begin
        n_mismatch++;
        give_verdict();
      end
      @(posedge core_clk);
    end
    @(posedge core_clk);
  endtask : wait_idle
  // ==========
  // read monitor
  always @(posedge core_clk) begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && exp_q.size() > 0) begin
      chk("readdata", exp_q[0].e & exp_q[0].m, avs_readdata & exp_q[0].m);
      void'(exp_q.pop_front());
    end
  end
  initial begin
    repeat (100000) @(posedge core_clk);
    n_mismatch++;
    give_verdict();
  end
  // ==========
  // sequence
  initial begin
    rst <= 1'b1;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd(OFF_ACC, {20'h0, ACC_RST}, 32'hfff);
    rd(OFF_DEC, {20'h0, DEC_RST}, 32'hfff);
    rd(OFF_MAX, {22'h0, MAX_RST}, 32'h3ff);
    rd(OFF_MIN, {20'h0, MIN_RST}, 32'hfff);
    rd(OFF_FS, {22'h0, FS_RST}, 32'h3ff);
    rd(OFF_MODE, {29'h0, SEL_RST}, 32'h7);
    rd(OFF_POS, 32'h0, 32'h3fffff);
    rd(OFF_STATUS, 32'h0, 32'h6);
    rd(6'h30, 32'h0, 32'hffffffff);
    cmd(CMD_RUN, 1'b1, 32'h3ff);
    chk("bridge", 32'h0, 32'(bridge_en));
    supply_ok <= 1'b1;
    bus(1'b0, OFF_STATUS, 32'h0);
    rd(OFF_STATUS, 32'h2, 32'h2);
    repeat (3) begin
      v = ($random(seed) & 32'h7ff) + 32'h1;
      wr(OFF_DEC, v);
      rd(OFF_DEC, v, 32'hfff);
    end
    for (int i = 0; i < 5; i++) begin
      wr(ra[i], wv[i]);
      rd(ra[i], ev[i], 32'hfff);
    end
    for (int m = 0; m < 8; m++) begin
      wr(OFF_MODE, 32'(m));
      rd(OFF_MODE, (m > 4) ? 32'h4 : 32'(m), 32'h7);
    end
    wr(OFF_MAX, 32'h3ff);
    p0 = mot_pos;
    cmd(CMD_MOVE, 1'b1, 32'h3);
    chk("bridge", 32'h1, 32'(bridge_en));
    wait_idle(30000);
    chk("motor", 32'(p0 + 22'sd3), 32'(mot_pos));
    rd(OFF_POS, 32'h3, 32'h3fffff);
    chk("elec", 32'h3, 32'(elec_pos));
    cmd(CMD_HREL, 1'b0, 32'h0);
    chk("alarm_o", 32'h0, 32'(alarm_o));
    chk("busy_o", 32'h0, 32'(busy_o));
    wr(OFF_MODE, 32'h2);
    chk("elec", 32'h0, 32'(elec_pos));
    wr(OFF_MODE, 32'h4);
    wr(OFF_POS, 32'h1fffff);
    cmd(CMD_MOVE, 1'b1, 32'h1);
    wait_idle(15000);
    rd(OFF_POS, 32'h200000, 32'h3fffff);
    p0 = mot_pos;
    cmd(CMD_TO_POSITION_CMD, 1'b0, 32'h1fffff);
    wait_idle(15000);
    chk("motor", 32'(p0 - 22'sd1), 32'(mot_pos));
    rd(OFF_POS, 32'h1fffff, 32'h3fffff);
    wr(OFF_FS, 32'h0);
    cmd(CMD_RUN, 1'b1, 32'h3ff);
    repeat (60) @(posedge core_clk);
    rd(OFF_STATUS, 32'h10, 32'h10);
    chk("fullstep", 32'h1, 32'(full_step_mode));
    cmd(CMD_RUN, 1'b1, 32'h3ff);
    chk("busy", 32'h0, 32'(busy_oe_n));
    cmd(CMD_HSTOP, 1'b1, 32'h0);
    wait_idle(100);
    repeat (60) @(posedge core_clk);
    rd(OFF_STATUS, 32'h4, 32'h14);
    chk("fullstep", 32'h0, 32'(full_step_mode));
    for (int op = 0; op < 10; op++) begin
      cmd(4'(op), 1'b1, 32'h1);
      chk("bridge", 32'h1, 32'(bridge_en));
      cmd(CMD_HREL, 1'b0, 32'h0);
      chk("bridge", 32'h0, 32'(bridge_en));
    end
    switch_in <= 1'b0;
    cmd(CMD_RELEASE, 1'b1, 32'h0);
    switch_in <= 1'b1;
    wait_idle(200);
    rd(OFF_POS, 32'h0, 32'h3fffff);
    p0 = mot_pos;
    wr(OFF_CMD, 32'h31);
    switch_in <= 1'b0;
    wait_idle(200);
    rd(OFF_MARK, 32'(mot_pos - p0), 32'h3fffff);
    cmd(CMD_RUN, 1'b1, 32'h0);
    cmd(CMD_SREL, 1'b0, 32'h0);
    wait_idle(200);
    chk("bridge", 32'h0, 32'(bridge_en));
    wr(OFF_DEC, 32'h123);
    standby_reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk("alarm", 32'h0, 32'(alarm_oe_n));
    standby_reset_n <= 1'b1;
    repeat (3) @(posedge core_clk);
    rd(OFF_DEC, {20'h0, DEC_RST}, 32'hfff);
    give_verdict();
  end
endmodule : tb_stepper_motion_profile_core
bind smp_core smp_core_properties i_props (.core_clk(core_clk), .rst(rst),
  .standby_reset_n(standby_reset_n), .supply_ok(supply_ok), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .step_pulse(step_pulse), .bridge_en(bridge_en),
  .full_step_mode(full_step_mode), .oscillator_output_pin(oscillator_output_pin),
  .alarm_oe_n(alarm_oe_n), .busy_oe_n(busy_oe_n));
